// *** src/wdw_pkg.sv ***
// wdw_pkg: constants shared by the windowed watchdog
// assumes: 8-bit register port, offsets are byte addresses
`default_nettype none
package wdw_pkg;
	localparam logic [7:0] WDW_CONTROL_A_REG_OFS   = 8'h00; // control_a_reg
	localparam logic [7:0] WDW_STATUS_OFS  = 8'h01; // status
	localparam logic [7:0] WDW_UNLOCK_OFS  = 8'h02; // change_protection_unlock
	localparam logic [7:0] WDW_DEBUG_OFS   = 8'h03; // debug lock clear port
	localparam logic [7:0] WDW_KEY         = 8'hD8; // io_register_key
	localparam int         WDW_KEY_WINDOW  = 4;     // instructions after key
	localparam int         WDW_PER_LSB     = 0;
	localparam int         WDW_WIN_LSB     = 4;
	localparam int         WDW_LOCK_BIT    = 7;
	localparam int         WDW_BUSY_BIT    = 0;
	localparam logic [3:0] WDW_SEL_OFF     = 4'h0;
	localparam logic [3:0] WDW_SEL_MAX     = 4'hB;
	localparam int         WDW_BASE_CLKS   = 8;     // 8 osc cycles at code 1
	localparam int         WDW_CNT_W       = 14;
	localparam int         WDW_OSC_HZ      = 1024;
	localparam int         WDW_SYS_HZ      = 200_000_000;
	typedef enum logic [1:0] {WDW_IDLE, WDW_ARM, WDW_CLOSED, WDW_OPEN} wdw_state_t;
endpackage
`default_nettype wire

// *** src/wdw_watchdog.sv ***
// wdw_watchdog: windowed watchdog, register side on clock, counter on osc clock
// assumes: clear requests are one-cycle pulses; inputs synchronous to clock
//
// How it works
// RQ1 - period codes 1 to 11 enable watchdog
// RQ2 - normal mode: resets when timeout expires
// RQ3 - each accepted clear restarts count
// RQ4 - eleven period codes, 8 to 8K cycles
// RQ5 - zero window field means normal mode
// RQ6 - nonzero window enables window mode
// RQ7 - clear during closed period resets system
// RQ8 - open period follows closed; clear required
// RQ9 - first closed period starts at first clear
// RQ10 - clear crossing takes 2-3 osc cycles
// RQ11 - counter runs on 1.024 kHz oscillator
// RQ12 - config writes synchronized, busy flag shown
// RQ13 - software avoids writes while busy
// RQ14 - lock blocks all control writes
// RQ15 - lock sets only; clears in debug
// RQ16 - reset value from fuse, lock follows
// RQ17 - key then protected write within four
// RQ18 - period, window, lock are protected
// RQ19 - unprotected writes leave fields unchanged
// RQ20 - debug halt stops and zeroes counter
// RQ21 - after debug, one normal period first
// RQ22 - keeps running while oscillator runs
// RQ23 - clear is single-cycle request pulse
`default_nettype none
module wdw_watchdog
	import wdw_pkg::*;
(
	input  wire logic       clock,           // system clock, 200 MHz
	input  wire logic       rst,             // async reset, active high
	input  wire logic       watchdog_osc_clock, // 1.024 kHz oscillator clock
	input  wire logic [7:0] boot_config_fuse, // fuse value for control_a_reg
	input  wire logic       instr_retire,    // one pulse per executed instruction
	input  wire logic       debug_halt,      // cpu halted in debug
	input  wire logic       watchdog_clear_instruction, // clear pulse
	input  wire logic [7:0] addr,            // register address
	input  wire logic [7:0] wdata,           // write data
	input  wire logic       wr,              // write strobe
	input  wire logic       rd,              // read strobe
	output logic      [7:0] rdata,           // read data, cycle after rd
	output logic            system_reset     // watchdog reset request
);
	import wdw_pkg::*;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [WDW_CNT_W-1:0] sel_len(input logic [3:0] sel);
		logic [WDW_CNT_W-1:0] v;
		v = WDW_CNT_W'(WDW_BASE_CLKS);
		if (sel == WDW_SEL_OFF || sel > WDW_SEL_MAX)
			sel_len = '0;
		else
			sel_len = v << (sel - 4'h1); // [RQ4]
	endfunction

	// ------------------------------------------------------------
	// system domain: registers and protection
	// ------------------------------------------------------------
	logic [7:0] ctrl_r;
	logic       lock_r;
	logic       busy_r;
	logic [2:0] key_cnt_r;
	logic       boot_r;
	logic [7:0] rdata_r;
	logic       cfg_tgl_r;
	logic       clr_tgl_r;
	logic       clr_busy_r;
	logic [1:0] cfg_ack_s_r;
	logic [1:0] clr_ack_s_r;
	logic       cfg_ack_d_r;
	logic       clr_ack_d_r;
	logic       cfg_tgl_o;
	logic       clr_tgl_o;

	wire        sel_ctrl   = (addr == WDW_CONTROL_A_REG_OFS);
	wire        sel_status = (addr == WDW_STATUS_OFS);
	wire        sel_unlock = (addr == WDW_UNLOCK_OFS);
	wire        sel_debug  = (addr == WDW_DEBUG_OFS);
	wire        unlocked   = (key_cnt_r != 3'h0); // [RQ17]
	wire        key_wr     = wr && sel_unlock && (wdata == WDW_KEY);
	wire        ctrl_wr    = wr && sel_ctrl && unlocked && !lock_r && !busy_r; // [RQ14] [RQ19] [RQ13]
	wire        lock_set   = wr && sel_status && unlocked && wdata[WDW_LOCK_BIT]; // [RQ15] [RQ18]
	wire        lock_clr   = wr && sel_debug && debug_halt; // [RQ15]
	wire        cfg_ack    = cfg_ack_s_r[1] ^ cfg_ack_d_r;
	wire        clr_ack    = clr_ack_s_r[1] ^ clr_ack_d_r;
	wire        clr_take   = watchdog_clear_instruction && !clr_busy_r; // [RQ10] [RQ23]
	wire [7:0]  status_val = {lock_r, 6'h00, busy_r};
	wire [7:0]  rd_mux     = sel_ctrl ? ctrl_r : (sel_status ? status_val : 8'h00);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			boot_r    <= 1'b1;
			ctrl_r    <= 8'h00;
			lock_r    <= 1'b0;
			key_cnt_r <= 3'h0;
		end else begin
			boot_r <= 1'b0;
			if (boot_r) begin
				ctrl_r <= boot_config_fuse; // [RQ16]
				lock_r <= (boot_config_fuse[WDW_PER_LSB +: 4] != WDW_SEL_OFF); // [RQ16]
			end else begin
				if (ctrl_wr)
					ctrl_r <= wdata; // [RQ1] [RQ6] [RQ18]
				if (lock_clr)
					lock_r <= 1'b0;
				else if (lock_set)
					lock_r <= 1'b1;
			end
			if (key_wr)
				key_cnt_r <= 3'(WDW_KEY_WINDOW);
			else if (instr_retire && unlocked)
				key_cnt_r <= key_cnt_r - 3'h1; // [RQ17]
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_r      <= 1'b0;
			cfg_tgl_r   <= 1'b0;
			cfg_ack_s_r <= 2'b00;
			cfg_ack_d_r <= 1'b0;
		end else begin
			cfg_ack_s_r <= {cfg_ack_s_r[0], cfg_tgl_o};
			cfg_ack_d_r <= cfg_ack_s_r[1];
			if (ctrl_wr || boot_r) begin
				cfg_tgl_r <= ~cfg_tgl_r;
				busy_r    <= 1'b1; // [RQ12]
			end else if (cfg_ack)
				busy_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			clr_busy_r  <= 1'b0;
			clr_tgl_r   <= 1'b0;
			clr_ack_s_r <= 2'b00;
			clr_ack_d_r <= 1'b0;
			rdata_r     <= 8'h00;
		end else begin
			clr_ack_s_r <= {clr_ack_s_r[0], clr_tgl_o};
			clr_ack_d_r <= clr_ack_s_r[1];
			if (clr_take) begin
				clr_tgl_r  <= ~clr_tgl_r;
				clr_busy_r <= 1'b1;
			end else if (clr_ack)
				clr_busy_r <= 1'b0;
			rdata_r  <= rd ? rd_mux : 8'h00;
		end
	end

	assign rdata = rdata_r;

	// ------------------------------------------------------------
	// oscillator domain: counter and window state
	// ------------------------------------------------------------
	logic [2:0]           cfg_s_r;
	logic [2:0]           clr_s_r;
	logic [1:0]           hlt_s_r;
	logic [7:0]           cfg_o_r;
	logic [WDW_CNT_W-1:0] cnt_r;
	wdw_state_t           st_r;
	logic                 fire_r;
	logic                 skip_r;

	assign cfg_tgl_o = cfg_s_r[2];
	assign clr_tgl_o = clr_s_r[2];

	wire                 cfg_new  = cfg_s_r[2] ^ cfg_s_r[1];
	wire                 clr_new  = clr_s_r[2] ^ clr_s_r[1]; // [RQ10]
	wire                 halted   = hlt_s_r[1];
	wire [3:0]           per_sel  = cfg_o_r[WDW_PER_LSB +: 4];
	wire [3:0]           win_sel  = cfg_o_r[WDW_WIN_LSB +: 4];
	wire                 enabled  = (sel_len(per_sel) != '0); // [RQ1]
	wire                 win_mode = (win_sel != WDW_SEL_OFF); // [RQ5] [RQ6]
	wire [WDW_CNT_W-1:0] open_len = sel_len(per_sel);
	wire [WDW_CNT_W-1:0] shut_len = sel_len(win_sel);
	wire                 open_end = (cnt_r + 1'b1 >= open_len);
	wire                 shut_end = (cnt_r + 1'b1 >= shut_len);

	// the fuse config passes through the same crossing as software writes,
	// so the counter never sees a half-changed control word
	always_ff @(posedge watchdog_osc_clock or posedge rst) begin // [RQ11] [RQ22]
		if (rst) begin
			cfg_s_r <= 3'b000;
			clr_s_r <= 3'b000;
			hlt_s_r <= 2'b00;
			cfg_o_r <= 8'h00;
		end else begin
			cfg_s_r <= {cfg_s_r[1:0], cfg_tgl_r};
			clr_s_r <= {clr_s_r[1:0], clr_tgl_r};
			hlt_s_r <= {hlt_s_r[0], debug_halt};
			if (cfg_new)
				cfg_o_r <= ctrl_r; // [RQ12]
		end
	end

	always_ff @(posedge watchdog_osc_clock or posedge rst) begin
		if (rst) begin
			cnt_r  <= '0;
			st_r   <= WDW_IDLE;
			fire_r <= 1'b0;
			skip_r <= 1'b0;
		end else if (halted) begin
			cnt_r  <= '0; // [RQ20]
			st_r   <= WDW_ARM;
			skip_r <= 1'b1;
		end else if (!enabled) begin
			cnt_r <= '0;
			st_r  <= WDW_IDLE;
		end else begin
			case (st_r)
			WDW_IDLE: begin
				cnt_r <= '0;
				st_r  <= win_mode ? WDW_ARM : WDW_OPEN; // [RQ9]
			end
			WDW_ARM: begin
				// after debug one normal period runs before any closed period
				if (skip_r && win_mode) begin
					cnt_r  <= '0;
					st_r   <= WDW_OPEN; // [RQ21]
					skip_r <= 1'b0;
				end else if (!win_mode)
					st_r <= WDW_OPEN;
				else if (clr_new) begin
					cnt_r <= '0;
					st_r  <= WDW_CLOSED; // [RQ9]
				end
			end
			WDW_CLOSED: begin
				if (clr_new)
					fire_r <= 1'b1; // [RQ7]
				else if (shut_end) begin
					cnt_r <= '0;
					st_r  <= WDW_OPEN; // [RQ8]
				end else
					cnt_r <= cnt_r + 1'b1;
			end
			WDW_OPEN: begin
				skip_r <= 1'b0;
				if (clr_new) begin
					cnt_r <= '0; // [RQ3]
					st_r  <= win_mode ? WDW_CLOSED : WDW_OPEN;
				end else if (open_end)
					fire_r <= 1'b1; // [RQ2] [RQ8]
				else
					cnt_r <= cnt_r + 1'b1;
			end
			default: st_r <= WDW_IDLE;
			endcase
		end
	end

	assign system_reset = fire_r;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: directed checks of wdw_watchdog
// assumes: osc sped up to 16 clocks a period so runs stay short
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import wdw_pkg::*;
	// ----
	// bench
	// ----
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       osc = 1'b0;
	logic       halt = 1'b0;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       clr_go = 1'b0;
	logic       retire;
	logic       clr;
	logic       sys_rst;
	logic [7:0] fuse = 8'h00;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] v;
	int         num_errors = 0;
	int         comparisons = 0;
	int         cyc = 0;
	initial forever #2.5 clock = ~clock;
	initial begin
		#13;
		forever #40 osc = ~osc;
	end
	wdw_cpu_model i_wdw_cpu_model (.clock(clock), .rst(rst), .clr_go(clr_go),
		.instr_retire(retire), .clear_pulse(clr));
	wdw_watchdog i_wdw_watchdog (.clock(clock), .rst(rst), .watchdog_osc_clock(osc),
		.boot_config_fuse(fuse), .instr_retire(retire), .debug_halt(halt),
		.watchdog_clear_instruction(clr), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .system_reset(sys_rst));
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] got, logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wr_t(logic [7:0] a, logic [7:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_t(logic [7:0] a);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		// read data stands from this edge to the next one only
		#1;
		v = rdata;
	endtask
	task automatic pw(logic [7:0] a, logic [7:0] d);
		wr_t(WDW_UNLOCK_OFS, WDW_KEY);
		wr_t(a, d);
	endtask
	task automatic boot(logic [7:0] f);
		@(posedge clock);
		rst <= 1'b1;
		fuse <= f;
		tick(20);
		rst <= 1'b0;
		tick(2);
	endtask
	task automatic clear_t;
		@(posedge clock);
		clr_go <= 1'b1;
		@(posedge clock);
		clr_go <= 1'b0;
	endtask
	task automatic settle;
		for (int i = 0; i < 100; i++) begin
			rd_t(WDW_STATUS_OFS);
			if (v[0] === 1'b0)
				break;
		end
		chk("busy", v & 8'h01, 8'h00);
	endtask
	task automatic t_protect;
		settle;
		rd_t(WDW_CONTROL_A_REG_OFS);
		chk("ctrl boot", v, 8'h00);
		wr_t(WDW_CONTROL_A_REG_OFS, 8'h02);
		rd_t(WDW_CONTROL_A_REG_OFS);
		chk("ctrl no key", v, 8'h00);
		wr_t(WDW_UNLOCK_OFS, WDW_KEY);
		tick(6);
		wr_t(WDW_CONTROL_A_REG_OFS, 8'h02);
		rd_t(WDW_CONTROL_A_REG_OFS);
		chk("ctrl key expired", v, 8'h00);
		rd_t(8'h05);
		chk("unmapped", v, 8'h00);
		pw(WDW_CONTROL_A_REG_OFS, 8'h02);
		rd_t(WDW_STATUS_OFS);
		chk("busy set", v, 8'h01);
		settle;
		rd_t(WDW_CONTROL_A_REG_OFS);
		chk("ctrl keyed", v, 8'h02);
	endtask
	task automatic t_clear;
		repeat (4) begin
			clear_t;
			tick(150);
			chk("kept", {7'h00, sys_rst}, 8'h00);
		end
		tick(100);
		chk("early", {7'h00, sys_rst}, 8'h00);
		tick(150);
		chk("timeout", {7'h00, sys_rst}, 8'h01);
	endtask
	task automatic t_window;
		boot(8'h00);
		settle;
		pw(WDW_CONTROL_A_REG_OFS, 8'h21);
		settle;
		tick(600);
		chk("armed", {7'h00, sys_rst}, 8'h00);
		clear_t;
		tick(80);
		clear_t;
		tick(150);
		chk("closed clear", {7'h00, sys_rst}, 8'h01);
	endtask
	task automatic t_lock;
		boot(8'h01);
		rd_t(WDW_CONTROL_A_REG_OFS);
		chk("ctrl fuse", v, 8'h01);
		rd_t(WDW_STATUS_OFS);
		chk("lock fuse", v & 8'h80, 8'h80);
		pw(WDW_CONTROL_A_REG_OFS, 8'h00);
		rd_t(WDW_CONTROL_A_REG_OFS);
		chk("ctrl locked", v, 8'h01);
		@(posedge clock);
		halt <= 1'b1;
		tick(600);
		chk("halted", {7'h00, sys_rst}, 8'h00);
		pw(WDW_DEBUG_OFS, 8'h00);
		rd_t(WDW_STATUS_OFS);
		chk("unlocked", v & 8'h80, 8'h00);
		@(posedge clock);
		halt <= 1'b0;
		tick(400);
		chk("resumed", {7'h00, sys_rst}, 8'h01);
	endtask
	initial begin
		boot(8'h00);
		t_protect;
		t_clear;
		t_window;
		t_lock;
		end_of_test;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_of_test;
		end
	end
endmodule
`default_nettype wire

// *** tb/wdw_checker.sv ***
// wdw_checker: port assertions for wdw_watchdog
// assumes: osc period about 16 system clocks
`default_nettype none
module wdw_checker
	import wdw_pkg::*;
(
	input wire logic       clock,            // system clock
	input wire logic       rst,              // async reset
	input wire logic [7:0] boot_config_fuse, // fuse value
	input wire logic       debug_halt,       // debug halt
	input wire logic [7:0] addr,             // address
	input wire logic       wr,               // write strobe
	input wire logic       rd,               // read strobe
	input wire logic [7:0] rdata,            // read data
	input wire logic       system_reset      // reset request
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// helpers
	// ----
	logic [8:0] up_r;
	logic [8:0] halt_r;
	logic       seen_r;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			up_r <= 9'h000;
			halt_r <= 9'h000;
			seen_r <= 1'b0;
		end else begin
			up_r <= up_r + {8'h00, up_r != 9'h1FF};
			halt_r <= debug_halt ? halt_r + {8'h00, halt_r != 9'h1FF} : 9'h000;
			seen_r <= seen_r | wr;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	property p_sticky; system_reset |=> system_reset; endproperty
	a_sticky: assert property (p_sticky) else $error("reset dropped");
	// shortest period is 8 osc cycles, about 128 clocks
	property p_min; up_r < 9'h078 |-> !system_reset; endproperty
	a_min: assert property (p_min) else $error("reset too early");
	property p_halt; halt_r > 9'h064 |-> !$rose(system_reset); endproperty
	a_halt: assert property (p_halt) else $error("reset while halted");
	property p_off; !seen_r && boot_config_fuse[3:0] == 4'h0 |-> !system_reset; endproperty
	a_off: assert property (p_off) else $error("reset while off");
	property p_idle; !$past(rd) |-> rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("stray read data");
	property p_unmap; rd && addr > 8'h03 |=> rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped not zero");
	property p_res; rd && addr == WDW_STATUS_OFS |=> rdata[6:1] == 6'h00; endproperty
	a_res: assert property (p_res) else $error("status spare bits");
	property p_lock; rd && addr == WDW_STATUS_OFS && !seen_r
		&& boot_config_fuse[3:0] != 4'h0 |=> rdata[7]; endproperty
	a_lock: assert property (p_lock) else $error("fuse lock missing");
endmodule
bind wdw_watchdog wdw_checker i_wdw_checker (.clock(clock), .rst(rst),
	.boot_config_fuse(boot_config_fuse), .debug_halt(debug_halt), .addr(addr),
	.wr(wr), .rd(rd), .rdata(rdata), .system_reset(system_reset));
`default_nettype wire

// *** tb/wdw_cpu_model.sv ***
// wdw_cpu_model: cpu side, one instruction a cycle, clear pulses
// assumes: clr_go driven by the bench on clock
`default_nettype none
module wdw_cpu_model (
	input  wire logic clock,        // system clock
	input  wire logic rst,          // async reset
	input  wire logic clr_go,       // bench asks for a clear
	output var logic  instr_retire, // retire pulse
	output var logic  clear_pulse   // one-cycle clear
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// cpu side
	// ----
	logic go_r;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			instr_retire <= 1'b0;
			clear_pulse <= 1'b0;
			go_r <= 1'b0;
		end else begin
			instr_retire <= 1'b1;
			clear_pulse <= clr_go & ~go_r;
			go_r <= clr_go;
		end
	end
endmodule
`default_nettype wire
